// [src/eeprom_host.sv]
// host controller driving an 8K x 8 parallel eeprom through its pins
// assumes a pull-up on the shared ready/busy line and level shifters that
// put 12 V on output-enable and on the id-row address line when asked
//
// How it works
// - write starts with a write-enable low pulse, chip on, outputs off
// - polling mode rereads the written address until bit 7 matches or the write-cycle timeout runs out
// - id row uses the high-voltage address line and 1fe0 to 1fff
// - chip clear: output-enable at 12 V, chip and write enables low
`timescale 1ns/1ps
module eeprom_host
  import eeprom_host_pkg::*;
#(
  parameter int WC_CYCLES    = WC_CYC,
  parameter int CLEAR_CYCLES = CLEAR_CYC
)(
  input  wire logic              clock,
  input  wire logic              srst,
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire logic              cmd_write,
  input  wire logic              cmd_clear,
  input  wire logic              cmd_id_row,
  input  wire logic              cmd_poll,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [DATA_W-1:0] cmd_wdata,
  output logic                   rsp_valid,
  output logic      [DATA_W-1:0] rsp_rdata,
  output logic                   rsp_timeout,
  output logic      [ADDR_W-1:0] mem_addr,
  output logic                   chip_en_n,
  output logic                   out_en_n,
  output logic                   write_en_n,
  output logic                   out_en_hv,
  output logic                   id_row_hv_addr_line,
  output logic      [DATA_W-1:0] data_out,
  output logic                   data_oe,
  input  wire logic [DATA_W-1:0] data_in,
  input  wire logic              ready_busy
);

  if (WC_CYCLES < 1 || WC_CYCLES >= (1 << CNT_W) ||
      CLEAR_CYCLES < 1 || CLEAR_CYCLES >= (1 << CNT_W))
  begin : g_bad_count
    $error("eeprom_host cycle counts must fit the counter");
  end

  host_state_e             state;
  logic [CNT_W-1:0]        cnt;
  logic [CNT_W-1:0]        tmo;
  logic                    polling;
  logic                    poll_mode;
  logic                    clearing;
  logic [DATA_W-1:0]       data_s;
  logic                    rdy_s;
  logic                    take;
  logic                    poll_hit;

  pin_sync #(
    .WIDTH       (DATA_W + 1),
    .RESET_VALUE ({1'b1, 8'h00})
  ) u_sync (
    .clock (clock),
    .srst  (srst),
    .pin   ({ready_busy, data_in}),
    .value ({rdy_s, data_s})
  );

  // writes and clears wait here for a ready memory
  assign take = cmd_valid && cmd_ready &&
                ((!cmd_write && !cmd_clear) || rdy_s);
  assign poll_hit = data_s[DATA_W-1] == data_out[DATA_W-1];

  // sequencer and pins
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state <= ST_IDLE;
      cnt <= '0;
      cmd_ready <= 1'b0;
      polling <= 1'b0;
      poll_mode <= 1'b0;
      clearing <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      rsp_timeout <= 1'b0;
      mem_addr <= '0;
      chip_en_n <= 1'b1;
      out_en_n <= 1'b1;
      write_en_n <= 1'b1;
      out_en_hv <= 1'b0;
      id_row_hv_addr_line <= 1'b0;
      data_out <= '0;
      data_oe <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      unique case (state)
        ST_IDLE:
        begin
          cmd_ready <= 1'b1;
          if (take)
          begin
            cmd_ready <= 1'b0;
            rsp_timeout <= 1'b0;
            poll_mode <= cmd_poll;
            clearing <= cmd_clear;
            data_out <= cmd_wdata;
            mem_addr <= cmd_addr;
            chip_en_n <= 1'b0;
            if (cmd_clear)
            begin
              // id row stays out of reach of a clear
              id_row_hv_addr_line <= 1'b0;
              write_en_n <= 1'b0;
              out_en_hv <= 1'b1;
              cnt <= CNT_W'(CLEAR_CYCLES - 1);
              state <= ST_CLEAR;
            end
            else
            begin
              if (cmd_id_row)
              begin
                mem_addr <= ID_ROW_BASE | cmd_addr;
              end
              id_row_hv_addr_line <= cmd_id_row;
              if (cmd_write)
              begin
                data_oe <= 1'b1;
                cnt <= CNT_W'(AS_CYC - 1);
                state <= ST_SETUP;
              end
              else
              begin
                out_en_n <= 1'b0;
                cnt <= CNT_W'(ACC_CYC + SYNC_LAT - 1);
                state <= ST_READ;
              end
            end
          end
        end
        ST_READ:
        begin
          if (cnt != '0)
          begin
            cnt <= cnt - 1'b1;
          end
          else
          begin
            chip_en_n <= 1'b1;
            out_en_n <= 1'b1;
            cnt <= CNT_W'(OFF_CYC - 1);
            state <= ST_GAP;
            if (!polling || poll_hit || tmo == '0)
            begin
              polling <= 1'b0;
              rsp_valid <= 1'b1;
              rsp_rdata <= data_s;
              rsp_timeout <= polling && !poll_hit;
            end
          end
        end
        ST_GAP:
        begin
          // memory outputs need toff to float before the next access
          if (cnt != '0)
          begin
            cnt <= cnt - 1'b1;
          end
          else if (polling)
          begin
            chip_en_n <= 1'b0;
            out_en_n <= 1'b0;
            cnt <= CNT_W'(ACC_CYC + SYNC_LAT - 1);
            state <= ST_READ;
          end
          else
          begin
            id_row_hv_addr_line <= 1'b0;
            cmd_ready <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_SETUP:
        begin
          if (cnt != '0)
          begin
            cnt <= cnt - 1'b1;
          end
          else
          begin
            write_en_n <= 1'b0;
            cnt <= CNT_W'(WPL_CYC - 1);
            state <= ST_PULSE;
          end
        end
        ST_PULSE:
        begin
          if (cnt != '0)
          begin
            cnt <= cnt - 1'b1;
          end
          else
          begin
            write_en_n <= 1'b1;
            cnt <= CNT_W'(AH_CYC - 1);
            state <= ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          if (cnt != '0)
          begin
            cnt <= cnt - 1'b1;
          end
          else
          begin
            chip_en_n <= 1'b1;
            data_oe <= 1'b0;
            cnt <= CNT_W'(DB_CYC + SYNC_LAT);
            state <= ST_WAIT;
          end
        end
        ST_CLEAR:
        begin
          if (cnt != '0)
          begin
            cnt <= cnt - 1'b1;
          end
          else
          begin
            write_en_n <= 1'b1;
            chip_en_n <= 1'b1;
            out_en_hv <= 1'b0;
            cnt <= CNT_W'(DB_CYC + SYNC_LAT);
            state <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          // busy may take tdb plus sync delay to show, so hold off sampling
          if (cnt != '0)
          begin
            cnt <= cnt - 1'b1;
          end
          else if (poll_mode && !clearing)
          begin
            polling <= 1'b1;
            chip_en_n <= 1'b0;
            out_en_n <= 1'b0;
            cnt <= CNT_W'(ACC_CYC + SYNC_LAT - 1);
            state <= ST_READ;
          end
          else if (rdy_s || tmo == '0)
          begin
            rsp_valid <= 1'b1;
            rsp_rdata <= data_out;
            rsp_timeout <= !rdy_s;
            id_row_hv_addr_line <= 1'b0;
            cmd_ready <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // write-cycle timeout, armed when the write pulse starts or the clear pulse ends
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      tmo <= '0;
    end
    else if (state == ST_SETUP || state == ST_CLEAR)
    begin
      tmo <= CNT_W'(WC_CYCLES);
    end
    else if (tmo != '0)
    begin
      tmo <= tmo - 1'b1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  chk_we_gating: assert property (
    !write_en_n |-> !chip_en_n && out_en_n)
    else $error("write pulse without chip on and outputs off");
  chk_we_width: assert property (
    $fell(write_en_n) && !out_en_hv |-> !write_en_n [*3] ##1 write_en_n)
    else $error("write pulse not three cycles");
  chk_no_contention: assert property (
    data_oe |-> out_en_n)
    else $error("host drives data while memory may drive");
  chk_id_range: assert property (
    id_row_hv_addr_line |-> mem_addr[12:5] == ID_ROW_TOP_BITS)
    else $error("id row address outside top range");
  chk_clear_levels: assert property (
    out_en_hv |-> out_en_n && !write_en_n && !chip_en_n &&
                  !id_row_hv_addr_line)
    else $error("clear levels wrong");
  chk_start_ready: assert property (
    $fell(chip_en_n) && out_en_n |-> $past(rdy_s))
    else $error("write started while busy");
  chk_data_hold: assert property (
    $rose(write_en_n) && !$past(out_en_hv) |->
      (data_oe && !chip_en_n && $stable(data_out) &&
       $stable(mem_addr)) [*2])
    else $error("data or address not held after write edge");
  chk_poll_match: assert property (
    rsp_valid && $past(polling) && !rsp_timeout |->
      rsp_rdata[7] == data_out[7])
    else $error("poll finished without bit 7 match");
  chk_idle_standby: assert property (
    cmd_ready |-> chip_en_n && write_en_n && !data_oe && !out_en_hv)
    else $error("idle with memory selected");

  cov_read: cover property (
    $fell(out_en_n) ##[1:20] rsp_valid);
  cov_poll_write: cover property (
    rsp_valid && $past(polling) && !rsp_timeout);
  cov_rdy_write: cover property (
    rsp_valid && $past(state == ST_WAIT) && !clearing && !rsp_timeout);
  cov_clear: cover property ($rose(out_en_hv));

endmodule

// [src/eeprom_host_pkg.sv]
// constants for the parallel eeprom host controller
// assumes a 25 MHz system clock and the slowest read grade of the memory
package eeprom_host_pkg;

  localparam int CLK_PERIOD_NS = 40;

  // memory geometry
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam logic [12:0] ID_ROW_BASE = 13'h1fe0;
  localparam logic [7:0] ID_ROW_TOP_BITS = 8'hff;

  // pin timing in ns, us or ms as each name says; least times round up to whole cycles
  localparam int T_ACC_NS = 250;
  localparam int T_AS_NS = 10;
  localparam int T_WPL_NS = 100;
  localparam int T_AH_NS = 50;
  localparam int T_OFF_NS = 70;
  localparam int T_DB_NS = 50;
  localparam int T_WC_US = 2000;
  localparam int T_CLEAR_MS = 10;

  localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AS_CYC = (T_AS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPL_CYC = (T_WPL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AH_CYC = (T_AH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OFF_CYC = (T_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DB_CYC = (T_DB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WC_CYC = (T_WC_US * 1000) / CLK_PERIOD_NS;
  localparam int CLEAR_CYC = (T_CLEAR_MS * 1000000) / CLK_PERIOD_NS;

  // pin input synchroniser depth
  localparam int SYNC_LAT = 3;

  localparam int CNT_W = 20;

  typedef enum logic [8:0] {
    ST_IDLE  = 9'b000000001,
    ST_READ  = 9'b000000010,
    ST_GAP   = 9'b000000100,
    ST_SETUP = 9'b000001000,
    ST_PULSE = 9'b000010000,
    ST_HOLD  = 9'b000100000,
    ST_WAIT  = 9'b001000000,
    ST_CLEAR = 9'b010000000,
    ST_SPARE = 9'b100000000
  } host_state_e;

endpackage

// [src/pin_sync.sv]
// three-stage synchroniser for pins arriving from outside the clock domain
// assumes pins may change at any time; a change is taken once stages 2 and 3
// agree
`timescale 1ns/1ps
module pin_sync
  import eeprom_host_pkg::*;
#(
  parameter int               WIDTH       = 9,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
)(
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] value
);

  if (WIDTH < 1)
  begin : g_bad_width
    $error("pin_sync width must be at least 1");
  end

  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    logic s1;
    logic s2;
    logic s3;
    logic v;

    // one driver per output bit
    assign value[i] = v;

    // s1 feeds s2 only, so a metastable first stage never reaches logic
    always_ff @(posedge clock)
    begin
      if (srst)
      begin
        s1 <= RESET_VALUE[i];
        s2 <= RESET_VALUE[i];
        s3 <= RESET_VALUE[i];
        v <= RESET_VALUE[i];
      end
      else
      begin
        s1 <= pin[i];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3)
        begin
          v <= s3;
        end
      end
    end
  end

endmodule

// [sim/eeprom_model.sv]
// behavioural 8k x 8 parallel eeprom seen from its pins
// assumes the bench resolves the data bus and pulls ready/busy up
`timescale 1ns/1ps
module eeprom_model
  import eeprom_host_pkg::*;
(
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              ce_n,
  input  wire logic              oe_n,
  input  wire logic              we_n,
  input  wire logic              oe_hv,
  input  wire logic              id_hv,
  input  wire logic [DATA_W-1:0] din,
  input  wire logic              slow,
  output logic      [DATA_W-1:0] dout,
  output logic                   drive,
  output logic                   busy
);
  logic    [DATA_W-1:0] mem [0:8191];
  logic    [DATA_W-1:0] idrow [0:31];
  logic    [ADDR_W-1:0] wa;
  logic    [DATA_W-1:0] wd;
  logic                 wid;
  logic                 junk;
  realtime              t_fall;

  function automatic logic is_id(input logic hv, input logic [12:0] a);
    return hv && a[12:5] == 8'hff;
  endfunction

  initial
  begin
    for (int i = 0; i < 8192; i++)
      mem[i] = 8'hff;
    for (int i = 0; i < 32; i++)
      idrow[i] = 8'hff;
    busy = 1'b0;  // supply taken as above the trip point
    junk = 1'b0;
    t_fall = 0;
    forever
      #20 junk = ~junk;
  end

  // a released bus shows a moving pattern, never the last value
  assign drive = !ce_n && !oe_n && we_n && !oe_hv;
  always @*
    if (!drive)
      dout = 8'h5a ^ {8{junk}};
    else if (busy && addr == wa && is_id(id_hv, addr) == wid)
      dout = {~wd[7], 7'h55 ^ {7{junk}}};
    else if (is_id(id_hv, addr))
      dout = idrow[addr[4:0]];
    else
      dout = mem[addr];

  // pins of one host edge change together; decide once all have settled
  always @(negedge we_n or negedge ce_n)
  begin
    #1;
    if (!we_n && !ce_n && !busy)
    begin
      wa = addr;
      wid = is_id(id_hv, addr);
      t_fall = $realtime;
      if (oe_hv)
      begin
        busy = 1'b1;
        #400;
        for (int i = 0; i < 8192; i++)
          mem[i] = 8'hff;  // id row untouched
        busy = 1'b0;
      end
    end
  end

  // busy only ever pulls the shared line low
  always @(posedge we_n or posedge ce_n)
  begin
    #1;
    if (!busy && we_n != ce_n && oe_n && !oe_hv
        && $realtime - t_fall >= 10.0)
    begin
      wd = din;
      busy = 1'b1;
      #(slow ? 20000 : 2000);
      if (wid)
        idrow[wa[4:0]] = wd;
      else
        mem[wa] = wd;
      busy = 1'b0;
    end
  end
endmodule

// [sim/test_eeprom_host.sv]
// self-checking bench for the eeprom host controller
// assumes the memory model on the pins and a pull-up on ready/busy
`timescale 1ns/1ps
module test_eeprom_host;
  import eeprom_host_pkg::*;
  // short write and clear limits keep the run brief
  localparam int WC = 200;
  localparam int CLR = 20;
  logic              clock, srst, cmd_valid, cmd_ready, cmd_write, cmd_clear;
  logic              cmd_id_row, cmd_poll, rsp_valid, rsp_timeout, slow;
  logic              chip_en_n, out_en_n, write_en_n, out_en_hv, id_hv;
  logic              data_oe, ready_busy, drive, busy, tmo, id, pl;
  logic [ADDR_W-1:0] cmd_addr, mem_addr, a;
  logic [DATA_W-1:0] cmd_wdata, rsp_rdata, data_out, data_in, mdout, rd, d;
  logic [DATA_W-1:0] mref [0:8191];
  logic [DATA_W-1:0] iref [0:31];
  int                n_fail = 0;
  int                tests_run = 0;
  int                lowcnt;

  assign data_in = data_oe ? data_out : mdout;
  assign ready_busy = busy ? 1'b0 : 1'b1;

  eeprom_host #(.WC_CYCLES(WC), .CLEAR_CYCLES(CLR)) eeprom_host_inst (
    .clock(clock), .srst(srst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_clear(cmd_clear),
    .cmd_id_row(cmd_id_row), .cmd_poll(cmd_poll), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_timeout(rsp_timeout), .mem_addr(mem_addr),
    .chip_en_n(chip_en_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
    .out_en_hv(out_en_hv), .id_row_hv_addr_line(id_hv),
    .data_out(data_out), .data_oe(data_oe), .data_in(data_in),
    .ready_busy(ready_busy));

  eeprom_model eeprom_model_inst (
    .addr(mem_addr), .ce_n(chip_en_n), .oe_n(out_en_n), .we_n(write_en_n),
    .oe_hv(out_en_hv), .id_hv(id_hv), .din(data_out), .slow(slow),
    .dout(mdout), .drive(drive), .busy(busy));

  function automatic logic [7:0] exp_byte(input logic i, input logic [12:0] x);
    return i ? iref[x[4:0]] : mref[x];
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (n_fail == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // called at a falling edge; waits for idle, hands over, waits for answer
  task automatic op(input logic wr, cl, i, p, input logic [12:0] x,
                    input logic [7:0] y);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100)
    begin
      @(negedge clock);
      n++;
    end
    {cmd_write, cmd_clear, cmd_id_row, cmd_poll} = {wr, cl, i, p};
    cmd_addr = x;
    cmd_wdata = y;
    cmd_valid = 1'b1;
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end
    while (cmd_ready !== 1'b0 && n < 20000);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20000)
    begin
      @(negedge clock);
      n++;
    end
    check({7'h0, rsp_valid}, 8'h01);
    rd = rsp_rdata;
    tmo = rsp_timeout;
  endtask

  initial
  begin
    clock = 1'b0;
    forever
      #20 clock = ~clock;
  end

  initial
  begin
    #3000000;
    n_fail++;
    close_out();
  end

  always @(negedge clock)
    if (srst)
      lowcnt <= 0;
    else
    begin
      if (write_en_n === 1'b0)
        lowcnt <= lowcnt + 1;
      else if (lowcnt != 0)
      begin
        check({7'h0, lowcnt >= 3}, 8'h01);
        lowcnt <= 0;
      end
      if (write_en_n === 1'b0 && out_en_hv === 1'b0)
        check({5'h0, chip_en_n, out_en_n, data_oe}, 8'h03);
      if (data_oe === 1'b1)
        check({7'h0, out_en_n}, 8'h01);
      if (cmd_ready === 1'b1)
        check({7'h0, chip_en_n}, 8'h01);
      if (drive === 1'b1)
        check({7'h0, data_oe}, 8'h00);
    end

  initial
  begin
    {srst, cmd_valid, cmd_write, cmd_clear, cmd_id_row, cmd_poll} = 6'h20;
    cmd_addr = '0;
    cmd_wdata = '0;
    slow = 1'b0;
    for (int i = 0; i < 8192; i++)
      mref[i] = 8'hff;
    for (int i = 0; i < 32; i++)
      iref[i] = 8'hff;
    void'($urandom(40));
    repeat (20) @(negedge clock);
    srst = 1'b0;
    // corners first: both array ends, main and id row
    for (int i = 0; i < 20; i++)
    begin
      a = (i < 4) ? {13{i[1]}} : 13'($urandom);
      d = (i < 4) ? 8'h10 + 8'(i) : 8'($urandom);
      id = (i < 4) ? i[0] : 1'($urandom);
      pl = 1'($urandom);
      op(1'b1, 1'b0, id, pl, a, d);
      check({7'h0, tmo}, 8'h00);
      check(rd, d);
      if (id)
        iref[a[4:0]] = d;
      else
        mref[a] = d;
      op(1'b0, 1'b0, id, 1'b0, a, 8'h00);
      check(rd, exp_byte(id, a));
    end
    // overlong write times out, next write must wait for ready
    slow = 1'b1;
    op(1'b1, 1'b0, 1'b0, 1'b0, 13'h0123, 8'h3c);
    check({7'h0, tmo}, 8'h01);
    op(1'b1, 1'b0, 1'b0, 1'b1, 13'h0125, 8'h5a);
    check({7'h0, tmo}, 8'h01);
    slow = 1'b0;
    op(1'b1, 1'b0, 1'b0, 1'b1, 13'h0124, 8'hc3);
    check({7'h0, tmo}, 8'h00);
    mref[13'h0123] = 8'h3c;
    mref[13'h0124] = 8'hc3;
    mref[13'h0125] = 8'h5a;
    op(1'b0, 1'b0, 1'b0, 1'b0, 13'h0123, 8'h00);
    check(rd, 8'h3c);
    op(1'b1, 1'b1, 1'b0, 1'b1, 13'h0000, 8'h00);
    check({7'h0, tmo}, 8'h00);
    for (int i = 0; i < 8192; i++)
      mref[i] = 8'hff;
    for (int j = 0; j < 6; j++)
    begin
      id = (j >= 4);
      a = (j == 1) ? 13'h1fff : (j == 2) ? 13'h0124 : {8'h0, 5'(j * 31)};
      op(1'b0, 1'b0, id, 1'b0, a, 8'h00);
      check(rd, exp_byte(id, a));
    end
    close_out();
  end
endmodule
